/* logic/synchronous_serial_port.sv */
// Synchronous serial port: master or slave, three frame formats
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
// Behaviour
// - Separate eight-word transmit and receive buffers
// - Even prescale divide from 2 to 254
// - Second divide by one plus rate divider
// - Empty slave transmit replays eighth older word
// - Fewer than eight writes sends zero
// - Received word shifted, then stored until read
// - Four interrupt sources ORed to one request
// - Mask bit one lets source through
// - Raw and masked status both readable
// - Word length 4 to 16, MSB first
// - Bit clock idle unless data moves
// - Timeout when data waits, clock idle
// - Active low select held whole frame in SPI and control-word formats
// - Pulsed format: one-period pulse, rise drive
// - Control word of eight bits, no capture
// - Pulsed idle: clock, select low, output off
// - Pulsed start: pulse, load, MSB next rise
// - Pulsed word stored on next rising edge
// - Polarity sets idle clock level in SPI format only
// - Phase picks first or second edge capture in SPI format only
// - SPI idle: select high, output low
// - Polarity and phase zero: rise samples
// - Phase zero: select rises between words
// - Phase one: select stays low between words
module synchronous_serial_port
   import ssp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Configuration
   input wire logic portEnable,
   input wire logic masterMode,
   input wire logic [1:0] frameFormat,
   input wire logic [3:0] wordSize,
   input wire logic idleClockPolarity,
   input wire logic capturePhase,
   input wire logic loopbackMode,
   input wire logic [7:0] prescaleDivisor,
   input wire logic [7:0] rateDivider,
   input wire logic [3:0] intMask,
   input wire logic [1:0] intClear,
   // Transmit words
   input wire logic txWrValid,
   input wire logic [15:0] txWrData,
   output logic txWrReady,
   // Receive words
   output logic rxRdValid,
   input wire logic rxRdReady,
   output logic [15:0] rxRdData,
   // Status
   output logic [3:0] rawIntStatus,
   output logic [3:0] maskedIntStatus,
   output logic intReq,
   output logic frameActive,
   // Serial pins
   input wire logic serialBitClockIn,
   output logic serialBitClockOut,
   output logic serialBitClockOe,
   input wire logic frameSelectIn,
   output logic frameSelectOut,
   output logic frameSelectOe,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutOe
);
   port_state_t s;
   port_state_t n;
   logic tick, doLoad, rxPush, rxWrReady, txRdValid, rxFifoValid, bufReady;
   logic isTi, isCw, preload, polEff, rxBit, clkEdge, lead, drvEdge, smpEdge;
   logic activity, rxHas;
   logic [15:0] txRdData, rxFifoData, rxPushData, ldWord, expHalf;
   logic [6:0] pscHalf;
   logic [4:0] nBits;
   logic [5:0] totalPer, sampleFrom, lastEdge, curPer;
   logic [3:0] txCount, rxCount;

   ////////////////////////////////////////////////////////////////////////////
   // Word buffers; the two-entry stage keeps a stalled reader from losing words
   ssp_fifo txFifo (
      .mclk(mclk), .srst(srst),
      .wrValid(txWrValid), .wrData(txWrData), .wrReady(txWrReady),
      .rdValid(txRdValid), .rdReady(doLoad), .rdData(txRdData), .count(txCount)
   );
   ssp_fifo rxFifo (
      .mclk(mclk), .srst(srst),
      .wrValid(rxPush), .wrData(rxPushData), .wrReady(rxWrReady),
      .rdValid(rxFifoValid), .rdReady(bufReady), .rdData(rxFifoData), .count(rxCount)
   );
   ssp_skid_buffer rxBuf (
      .mclk(mclk), .srst(srst),
      .inValid(rxFifoValid), .inReady(bufReady), .inData(rxFifoData),
      .outValid(rxRdValid), .outReady(rxRdReady), .outData(rxRdData)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the whole port
   always_comb begin
      n = s;
      tick = 1'b0;
      doLoad = 1'b0;
      rxPush = 1'b0;
      rxPushData = s.rxSh;
      // Format decode; first-bit preload for phase zero and control word
      isTi = frameFormat == `FMT_PULSED;
      isCw = frameFormat == `FMT_CTRLWORD;
      preload = isCw || (frameFormat == `FMT_SPI && !capturePhase);
      polEff = (frameFormat == `FMT_SPI) && idleClockPolarity;
      nBits = {1'b0, wordSize} + 5'h01;
      sampleFrom = isTi ? 6'h01 : (isCw ? `CTRL_BITS + 6'h01 : 6'h00);
      totalPer = {1'b0, nBits} + sampleFrom;
      lastEdge = {totalPer[4:0], 1'b0} - 6'h01;
      curPer = {1'b0, s.edgeCnt[5:1]};
      // MSB aligned to bit 15; control word sends low byte only
      ldWord = isCw ? {txRdData[7:0], 8'h00} : txRdData << (4'hF - wordSize);
      pscHalf = (prescaleDivisor[7:1] == 7'h00) ? 7'h01 : prescaleDivisor[7:1];
      expHalf = {9'h000, pscHalf} * ({8'h00, rateDivider} + 16'h0001);

      // Pin synchronisers; a change counts when stages two and three agree
      n.sClk = {s.sClk[1:0], serialBitClockIn};
      n.sFss = {s.sFss[1:0], frameSelectIn};
      n.sRx = {s.sRx[1:0], serialIn};
      if (s.sClk[1] == s.sClk[2]) n.fClk = s.sClk[2];
      if (s.sFss[1] == s.sFss[2]) n.fFss = s.sFss[2];
      if (s.sRx[1] == s.sRx[2]) n.fRx = s.sRx[2];
      rxBit = loopbackMode ? s.txO : n.fRx;
      clkEdge = n.fClk != s.fClk;
      lead = clkEdge && (n.fClk != polEff);
      drvEdge = clkEdge && (lead != preload);
      smpEdge = clkEdge && (lead == preload);

      // Half-period tick: half of the even prescale, times one plus rate
      if (!masterMode || s.st == ST_IDLE) begin
         n.pscCnt = 7'h00;
         n.rateCnt = 8'h00;
      end else if (s.pscCnt == pscHalf - 7'h01) begin
         n.pscCnt = 7'h00;
         if (s.rateCnt == rateDivider) begin
            n.rateCnt = 8'h00;
            tick = 1'b1;
         end else begin
            n.rateCnt = s.rateCnt + 8'h01;
         end
      end else begin
         n.pscCnt = s.pscCnt + 7'h01;
      end

      // Master sequencer; the pad enables follow the role
      n.clkOe = masterMode;
      n.fssOe = masterMode;
      case (s.st)
         ST_IDLE: begin
            n.clkO = polEff;
            n.fssO = !isTi;
            n.txO = 1'b0;
            n.txOe = !isTi;
            if (masterMode && portEnable && txRdValid) begin
               doLoad = 1'b1;
               n.txSh = ldWord;
               n.rxSh = 16'h0000;
               n.edgeCnt = 6'h00;
               n.txOe = 1'b1;
               n.fssO = 1'b0;
               n.st = isTi ? ST_SHIFT : ST_LEAD;
            end
         end
         ST_LEAD: begin
            if (tick) begin
               if (preload) begin
                  n.txO = s.txSh[15];
                  n.txSh = s.txSh << 1;
               end
               n.st = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (tick) begin
               n.clkO = !s.clkO;
               n.edgeCnt = s.edgeCnt + 6'h01;
               if (isTi) n.fssO = s.edgeCnt < 6'h02;
               if (s.edgeCnt[0] == preload) begin
                  // Drive edge; the pulse period and the preloaded last bit send nothing
                  if (!(isTi && curPer == 6'h00) && !(preload && curPer == totalPer - 6'h01)) begin
                     n.txO = s.txSh[15];
                     n.txSh = s.txSh << 1;
                  end
               end else if (curPer >= sampleFrom) begin
                  n.rxSh = {s.rxSh[14:0], rxBit};
               end
               if (s.edgeCnt == lastEdge) n.st = ST_END;
            end
         end
         ST_END: begin
            if (tick) begin
               rxPush = 1'b1;
               if (portEnable && txRdValid && (isTi || (frameFormat == `FMT_SPI && capturePhase))) begin
                  // Back to back: pulse again, or keep select low in phase one
                  doLoad = 1'b1;
                  n.txSh = ldWord;
                  n.rxSh = 16'h0000;
                  n.st = ST_SHIFT;
                  n.edgeCnt = isTi ? 6'h01 : 6'h00;
                  n.clkO = isTi || s.clkO;
                  n.fssO = isTi;
               end else begin
                  n.fssO = !isTi;
                  n.txOe = !isTi;
                  n.txO = 1'b0;
                  n.st = ST_GAP;
               end
            end
         end
         ST_GAP: begin
            if (tick) n.st = ST_IDLE;
         end
         default: n.st = ST_IDLE;
      endcase

      // Slave engine works on the filtered pins only
      if (!masterMode && portEnable) begin
         if (!isTi && s.fFss && !n.fFss) begin
            doLoad = 1'b1;
            n.slvAct = 1'b1;
            n.rxCnt = 5'h00;
            n.rxSh = 16'h0000;
            n.txO = preload && ldWord[15];
            n.txSh = preload ? ldWord << 1 : ldWord;
         end else if (isTi && lead && n.fFss) begin
            doLoad = 1'b1;
            n.slvAct = 1'b1;
            n.rxCnt = 5'h00;
            n.rxSh = 16'h0000;
            n.txSh = ldWord;
         end else if (s.slvAct && drvEdge) begin
            n.txO = s.txSh[15];
            n.txSh = s.txSh << 1;
         end
         if (s.slvAct && smpEdge && !(isTi && n.fFss)) begin
            n.rxSh = {s.rxSh[14:0], rxBit};
            n.rxCnt = s.rxCnt + 5'h01;
            if (s.rxCnt == nBits - 5'h01) begin
               rxPush = 1'b1;
               rxPushData = n.rxSh;
               n.rxCnt = 5'h00;
               if (isTi) begin
                  n.slvAct = 1'b0;
               end else if (frameFormat == `FMT_SPI && capturePhase) begin
                  doLoad = 1'b1;
                  n.txSh = ldWord;
                  n.rxSh = 16'h0000;
               end
            end
         end
         if (!isTi && n.fFss) n.slvAct = 1'b0;
      end else begin
         n.slvAct = 1'b0;
      end
      if (!masterMode) n.txOe = n.slvAct;
      if (!portEnable) n.st = ST_IDLE;

      // Receive timeout counts system cycles while data waits and the clock rests
      activity = (masterMode && s.st != ST_IDLE) || clkEdge;
      rxHas = rxCount != 4'h0 || rxRdValid;
      if (!rxHas || activity) begin
         n.toCnt = 16'h0000;
      end else if (s.toCnt != `RX_TIMEOUT_CYCLES) begin
         n.toCnt = s.toCnt + 16'h0001;
      end

      // Interrupts: set beats clear on the sticky bits
      n.raw[`INT_TX] = txCount <= `TX_SERVICE_LEVEL;
      n.raw[`INT_RX] = rxCount >= `RX_SERVICE_LEVEL;
      n.raw[`INT_RT] = (n.toCnt == `RX_TIMEOUT_CYCLES && s.toCnt != `RX_TIMEOUT_CYCLES) ||
                       (s.raw[`INT_RT] && !intClear[0]);
      n.raw[`INT_OR] = (rxPush && !rxWrReady) || (s.raw[`INT_OR] && !intClear[1]);
      n.masked = n.raw & intMask;
      n.irq = |n.masked;
      n.busy = n.st != ST_IDLE || n.slvAct;
      // Tick spacing monitor, cleared while the master sequencer is idle, so back-to-back frames share one count
      if (!masterMode || s.st == ST_IDLE) begin
         n.gapCnt = 16'h0000;
      end else if (tick) begin
         n.gapCnt = 16'h0001;
      end else if (s.gapCnt != 16'h0000) begin
         n.gapCnt = s.gapCnt + 16'h0001;
      end
   end

   // State register; select idles high so no false frame start
   always_ff @(posedge mclk) begin
      if (srst) begin
         s <= '0;
         s.sFss <= 3'h7;
         s.fFss <= 1'b1;
         s.fssO <= 1'b1;
         s.txOe <= 1'b1;
         s.raw[`INT_TX] <= 1'b1;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign rawIntStatus = s.raw;
   assign maskedIntStatus = s.masked;
   assign intReq = s.irq;
   assign frameActive = s.busy;
   assign serialBitClockOut = s.clkO;
   assign serialBitClockOe = s.clkOe;
   assign frameSelectOut = s.fssO;
   assign frameSelectOe = s.fssOe;
   assign serialOut = s.txO;
   assign serialOutOe = s.txOe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks and scenarios
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   property p_rate;
      (tick && s.gapCnt != 16'h0000 && $stable(prescaleDivisor) && $stable(rateDivider)) |-> s.gapCnt == expHalf;
   endproperty
   a_rate: assert property (p_rate) else $error("bit clock half period wrong");
   property p_idle_clk;
      (masterMode && s.st == ST_IDLE && $past(s.st) == ST_IDLE && $stable(frameFormat) && $stable(idleClockPolarity))
         |-> serialBitClockOut == polEff;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("idle clock level wrong");
   property p_spi_select;
      (masterMode && frameFormat == `FMT_SPI && (s.st == ST_SHIFT || s.st == ST_END)) |-> !frameSelectOut;
   endproperty
   a_spi_select: assert property (p_spi_select) else $error("select high inside frame");
   property p_pulsed_idle;
      (masterMode && isTi && s.st == ST_IDLE && $past(s.st) == ST_IDLE && $past(isTi))
         |-> !serialOutOe && !frameSelectOut && !serialBitClockOut;
   endproperty
   a_pulsed_idle: assert property (p_pulsed_idle) else $error("pulsed idle pins wrong");
   property p_pulse_rise;
      (masterMode && isTi && $rose(frameSelectOut)) |-> serialBitClockOut;
   endproperty
   a_pulse_rise: assert property (p_pulse_rise) else $error("pulse not on rising clock");
   property p_irq;
      1'b1 |-> intReq == (|maskedIntStatus);
   endproperty
   a_irq: assert property (p_irq) else $error("request not OR of masked");
   property p_masked;
      1'b1 |=> maskedIntStatus == (rawIntStatus & $past(intMask));
   endproperty
   a_masked: assert property (p_masked) else $error("masked status mismatch");
   property p_overrun;
      (rxPush && !rxWrReady) |=> rawIntStatus[`INT_OR];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");
   property p_timeout;
      (n.toCnt == `RX_TIMEOUT_CYCLES && s.toCnt != `RX_TIMEOUT_CYCLES) |=> rawIntStatus[`INT_RT];
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout not flagged");
   c_pulsed_word: cover property (masterMode && isTi && rxPush);
   c_spi_back_to_back: cover property (masterMode && capturePhase && s.st == ST_END && doLoad);
   c_slave_underrun: cover property (!masterMode && doLoad && !txRdValid);
   c_ctrl_frame: cover property (masterMode && isCw && rxPush);
endmodule
`default_nettype wire

/* logic/ssp_map.svh */
// Constant map of the synchronous serial port: levels, encodings and counts
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
// Word width and buffer depth
`define WORD_W 16
`define FIFO_DEPTH 4'h8
// Control message length of the half-duplex format
`define CTRL_BITS 6'h08
// Service levels of the buffer interrupts
`define TX_SERVICE_LEVEL 4'h4
`define RX_SERVICE_LEVEL 4'h4
// Idle cycles before a receive timeout is flagged
`define RX_TIMEOUT_CYCLES 16'h0200
// Frame format encodings
`define FMT_SPI 2'h0
`define FMT_PULSED 2'h1
`define FMT_CTRLWORD 2'h2
// Interrupt bit positions
`define INT_TX 0
`define INT_RX 1
`define INT_RT 2
`define INT_OR 3
`endif

/* logic/ssp_pkg.sv */
// Types shared by the synchronous serial port modules
package ssp_pkg;
   // Master frame sequencer
   typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_END, ST_GAP} mstate_t;
   // Word buffer state
   typedef struct packed {
      logic [7:0][15:0] mem;
      logic [2:0] wrPtr;
      logic [2:0] rdPtr;
      logic [3:0] cnt;
      logic notFull;
      logic notEmpty;
   } fifo_state_t;
   // Two-entry buffer state
   typedef struct packed {
      logic [15:0] d0;
      logic [15:0] d1;
      logic v0;
      logic v1;
   } skid_state_t;
   // Port state
   typedef struct packed {
      mstate_t st;
      logic [6:0] pscCnt;
      logic [7:0] rateCnt;
      logic [5:0] edgeCnt;
      logic [4:0] rxCnt;
      logic [15:0] txSh;
      logic [15:0] rxSh;
      logic [2:0] sClk;
      logic [2:0] sFss;
      logic [2:0] sRx;
      logic fClk;
      logic fFss;
      logic fRx;
      logic slvAct;
      logic [15:0] toCnt;
      logic [15:0] gapCnt;
      logic [3:0] raw;
      logic [3:0] masked;
      logic irq;
      logic busy;
      logic clkO;
      logic clkOe;
      logic fssO;
      logic fssOe;
      logic txO;
      logic txOe;
   } port_state_t;
endpackage

/* logic/ssp_fifo.sv */
// Eight by sixteen word buffer that keeps old words for underrun replay
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module ssp_fifo
   import ssp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Write side
   input wire logic wrValid,
   input wire logic [15:0] wrData,
   output logic wrReady,
   // Read side
   output logic rdValid,
   input wire logic rdReady,
   output logic [15:0] rdData,
   output logic [3:0] count
);
   fifo_state_t s;
   fifo_state_t n;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////////
   // Next state; a pop on empty leaves the pointer so the same old word replays
   always_comb begin
      n = s;
      push = wrValid && s.notFull;
      pop = rdReady && s.notEmpty;
      if (push) begin
         n.mem[s.wrPtr] = wrData;
         n.wrPtr = s.wrPtr + 3'h1;
      end
      if (pop) begin
         n.rdPtr = s.rdPtr + 3'h1;
      end
      n.cnt = s.cnt + {3'h0, push} - {3'h0, pop};
      n.notFull = n.cnt != `FIFO_DEPTH;
      n.notEmpty = n.cnt != 4'h0;
   end

   // Memory clears at reset, so an early underrun sends zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         s <= '0;
         s.notFull <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign wrReady = s.notFull;
   assign rdValid = s.notEmpty;
   assign rdData = s.mem[s.rdPtr];
   assign count = s.cnt;

   ////////////////////////////////////////////////////////////////////////////
   property p_full_refuse;
      @(posedge mclk) disable iff (srst)
         (s.cnt == `FIFO_DEPTH) |-> !wrReady ##1 (s.cnt == $past(s.cnt) - {3'h0, $past(rdReady)});
   endproperty
   a_full_refuse: assert property (p_full_refuse) else $error("full buffer took a word");
   property p_replay;
      @(posedge mclk) disable iff (srst) (rdReady && !rdValid && !wrValid) |=> $stable(s.rdPtr) && $stable(s.cnt);
   endproperty
   a_replay: assert property (p_replay) else $error("empty read moved the pointer");
endmodule
`default_nettype wire

/* logic/ssp_skid_buffer.sv */
// Two-entry registered buffer between receive store and reader
`timescale 1ns/1ps
`default_nettype none
module ssp_skid_buffer
   import ssp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [15:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [15:0] outData
);
   skid_state_t s;
   skid_state_t n;

   ////////////////////////////////////////////////////////////////////////////
   // Second entry absorbs a word while the reader stalls
   always_comb begin
      n = s;
      if (outReady && s.v0) begin
         n.v0 = s.v1;
         n.d0 = s.d1;
         n.v1 = 1'b0;
      end
      if (inValid && !s.v1) begin
         if (!n.v0) begin
            n.v0 = 1'b1;
            n.d0 = inData;
         end else begin
            n.v1 = 1'b1;
            n.d1 = inData;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Ready comes from a flop; only the second entry stalls the source
   assign inReady = !s.v1;
   assign outValid = s.v0;
   assign outData = s.d0;
endmodule
`default_nettype wire

/* dv/ssp_slave_model.sv */
// Off-chip serial peripheral in slave role, clock polarity and phase zero
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_model (
   // Serial pins seen from the slave
   input wire logic sclk,
   input wire logic selectN,
   input wire logic mosi,
   output logic miso,
   // Word returned and word captured
   input wire logic [15:0] reply,
   input wire logic [3:0] size,
   input wire logic ctrl,
   output logic [15:0] got
);
   integer idx;
   initial miso = 1'b0;
   // Selection puts the top bit out at once; a control-word answer waits nine falls
   always @(negedge selectN) begin
      got = 16'h0000;
      idx = ctrl ? size + 9 : size;
      miso = (idx <= size) ? reply[idx] : 1'b0;
   end
   // Capture on rising edges while selected
   always @(posedge sclk) if (!selectN) got = {got[14:0], mosi};
   // Change on falling edges
   always @(negedge sclk) if (!selectN) begin
      idx = idx - 1;
      if (idx >= 0) miso = (idx <= size) ? reply[idx] : 1'b0;
   end
   // A deselected slave no longer holds the last bit
   always @(posedge selectN) miso = ~miso;
endmodule
`default_nettype wire

/* dv/tb_synchronous_serial_port.sv */
// Self-checking bench of the serial port in master role
`timescale 1ns/1ps
`default_nettype none
module tb_synchronous_serial_port;
   import ssp_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, portEnable = 1'b0, idleClockPolarity = 1'b0, loopbackMode = 1'b0;
   logic txWrValid = 1'b0, rxRdReady = 1'b0;
   logic [15:0] txWrData = 16'h0000, slvGot, rd;
   logic [3:0] intMask = 4'h0, rawIntStatus, maskedIntStatus, wordSize = 4'h7;
   logic [1:0] frameFormat = 2'h0, intClear = 2'h0;
   logic capturePhase = 1'b0;
   logic [7:0] rateDivider = 8'h03;
   logic txWrReady, rxRdValid, intReq, frameActive, sclk, sclkOe, fss, fssOe, sout, soutOe, miso;
   logic [15:0] rxRdData;
   int errors = 0, n_checks = 0;
   localparam logic [15:0] REPLY = 16'hA5C3;
   always #4 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Design and far side; pin clock and select inputs idle in master role
   synchronous_serial_port uut (.mclk(mclk), .srst(srst), .portEnable(portEnable), .masterMode(1'b1),
      .frameFormat(frameFormat), .wordSize(wordSize), .idleClockPolarity(idleClockPolarity),
      .capturePhase(capturePhase), .loopbackMode(loopbackMode), .prescaleDivisor(8'h02),
      .rateDivider(rateDivider), .intMask(intMask),
      .intClear(intClear), .txWrValid(txWrValid), .txWrData(txWrData), .txWrReady(txWrReady),
      .rxRdValid(rxRdValid), .rxRdReady(rxRdReady), .rxRdData(rxRdData), .rawIntStatus(rawIntStatus),
      .maskedIntStatus(maskedIntStatus), .intReq(intReq), .frameActive(frameActive),
      .serialBitClockIn(1'b0), .serialBitClockOut(sclk), .serialBitClockOe(sclkOe),
      .frameSelectIn(1'b1), .frameSelectOut(fss), .frameSelectOe(fssOe), .serialIn(miso),
      .serialOut(sout), .serialOutOe(soutOe));
   ssp_slave_model slave (.sclk(sclk), .selectN(fss), .mosi(sout), .miso(miso), .reply(REPLY),
      .size(wordSize), .ctrl(frameFormat == 2'h2), .got(slvGot));
   ////////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hold the word until the buffer takes it
   task automatic put(input logic [15:0] d);
      txWrData = d;
      txWrValid = 1'b1;
      do @(posedge mclk); while (txWrReady !== 1'b1);
      #1 txWrValid = 1'b0;
      // One idle edge so a following call never re-raises valid in the same step
      @(posedge mclk) #1;
   endtask
   // Bounded wait for a received word, then take it
   task automatic get(output logic [15:0] d);
      int n;
      for (n = 0; n < 400 && rxRdValid !== 1'b1; n++) @(posedge mclk) #1;
      if (rxRdValid !== 1'b1) errors++;
      d = rxRdData;
      rxRdReady = 1'b1;
      @(posedge mclk) #1 rxRdReady = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk(txWrReady, 1'b1);
      chk(rxRdValid, 1'b0);
      chk(rawIntStatus, 4'h1);
      chk(intReq, 1'b0);
      chk(fss, 1'b1);
      chk(sout, 1'b0);
   endtask
   task automatic t_frame;
      put(16'h1E96);
      chk(fss, 1'b0);
      chk(frameActive, 1'b1);
      get(rd);
      chk(slvGot, 16'h0096);
      chk(rd, REPLY & 16'h00FF);
      repeat (12) @(posedge mclk) #1;
      chk(fss, 1'b1);
      chk(sclk, 1'b0);
      chk(frameActive, 1'b0);
      chk(sclkOe, 1'b1);
      chk(fssOe, 1'b1);
      chk(soutOe, 1'b1);
      idleClockPolarity = 1'b1;
      repeat (3) @(posedge mclk) #1;
      chk(sclk, 1'b1);
      idleClockPolarity = 1'b0;
   endtask
   task automatic t_loop;
      loopbackMode = 1'b1;
      put(16'h003C);
      get(rd);
      chk(rd, 16'h003C);
      loopbackMode = 1'b0;
   endtask
   // Receiver stalls while eight frames wait in its store, then drains
   task automatic t_fill;
      int i;
      portEnable = 1'b0;
      for (i = 0; i < 8; i++) put(16'h0040 + i);
      @(posedge mclk) #1;
      chk(txWrReady, 1'b0);
      portEnable = 1'b1;
      repeat (1400) @(posedge mclk) #1;
      intMask = 4'h4;
      repeat (3) @(posedge mclk) #1;
      chk(rawIntStatus, 4'h7);
      chk(maskedIntStatus, 4'h4);
      chk(intReq, 1'b1);
      intMask = 4'h0;
      for (i = 0; i < 8; i++) begin
         get(rd);
         chk(rd, REPLY & 16'h00FF);
      end
      repeat (3) @(posedge mclk) #1;
      chk(rxRdValid, 1'b0);
      chk(intReq, 1'b0);
      intClear = 2'h1;
      @(posedge mclk) #1 intClear = 2'h0;
      chk(rawIntStatus, 4'h1);
   endtask
   // Pulsed and phase-one frames through loopback, then a control-word frame
   task automatic t_formats;
      loopbackMode = 1'b1;
      frameFormat = 2'h1;
      repeat (3) @(posedge mclk) #1;
      chk(soutOe, 1'b0);
      chk(fss, 1'b0);
      put(16'h005A);
      get(rd);
      chk(rd, 16'h005A);
      frameFormat = 2'h0;
      capturePhase = 1'b1;
      put(16'h00C6);
      put(16'h0017);
      get(rd);
      chk(rd, 16'h00C6);
      get(rd);
      chk(rd, 16'h0017);
      capturePhase = 1'b0;
      loopbackMode = 1'b0;
      frameFormat = 2'h2;
      wordSize = 4'h3;
      put(16'h0096);
      get(rd);
      chk(slvGot, 16'h12C0);
      chk(rd, 16'h0003);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      repeat (20) @(posedge mclk);
      #1 srst = 1'b0;
      t_reset();
      portEnable = 1'b1;
      t_frame();
      t_loop();
      t_fill();
      t_formats();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
